// ---- verilog/mibc_counter_read.sv ----
// Statistics counter store with indirect host readout, read-clear for the port counters
`timescale 1ns/1ns

module mibc_counter_read #(
  parameter int NPORTS = mibc_pkg::NUM_PORTS,
  parameter int NDROP = mibc_pkg::NUM_DROP
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Management register access
  input wire mibc_pkg::mibc_req_t mgmtReq,
  output logic [7:0] mgmtRdData,
  output logic mgmtRdValid,
  // Counting events, one pulse adds one
  input wire logic [NPORTS*mibc_pkg::BANK_SIZE-1:0] portEvent,
  input wire logic [NDROP-1:0] dropEvent,
  // Status
  output logic readDone
);

  localparam int NCNT = NPORTS * mibc_pkg::BANK_SIZE;

  // ****************************************
  // Select and trigger registers
  // ****************************************
  // A trigger under any select other than the two counter kinds is ignored:
  // no snapshot, no done pulse and no clear. Select bit 0 becomes address
  // bit 8, so the drop counters sit above the eight-bit trigger range.
  logic [7:0] select_ff;
  logic [7:0] nxt_select;
  logic [7:0] trigger_ff;
  logic [7:0] nxt_trigger;
  logic trigWr;
  logic [8:0] trigAddr;
  logic isPortSel;
  logic isDropSel;
  logic portHit;
  logic dropHit;
  logic [8:0] dropIdx;

  // Decode of a trigger write and its indirect address
  always_comb begin
    trigWr = mgmtReq.wr && (mgmtReq.addr == mibc_pkg::REG_TRIGGER);
    trigAddr = {select_ff[0], mgmtReq.wdata};
    isPortSel = (select_ff == mibc_pkg::SEL_PORT_CNT);
    isDropSel = (select_ff == mibc_pkg::SEL_DROP_CNT);
    portHit = trigWr && isPortSel && (trigAddr < mibc_pkg::PORT_END);
    dropHit = trigWr && isDropSel && (trigAddr >= mibc_pkg::DROP_BASE)
      && (trigAddr < mibc_pkg::DROP_END);
    dropIdx = trigAddr - mibc_pkg::DROP_BASE;
  end

  // Next values of select and trigger
  always_comb begin
    nxt_select = select_ff;
    nxt_trigger = trigger_ff;
    if (mgmtReq.wr && (mgmtReq.addr == mibc_pkg::REG_SELECT)) begin
      nxt_select = mgmtReq.wdata;
    end
    if (trigWr) begin
      nxt_trigger = mgmtReq.wdata;
    end
  end

  // Register select and trigger
  always_ff @(posedge clock) begin
    if (rst) begin
      select_ff <= mibc_pkg::BYTE_RST;
      trigger_ff <= mibc_pkg::BYTE_RST;
    end else begin
      select_ff <= nxt_select;
      trigger_ff <= nxt_trigger;
    end
  end

  // ****************************************
  // Per-port counter banks
  // ****************************************
  // A wrap flag stays set until that very counter is read; the host cannot
  // clear it any other way.
  logic [mibc_pkg::CNT_W-1:0] cntVal [NCNT];
  logic [NCNT-1:0] ovfVal;
  logic [NCNT-1:0] clrVec;
  logic [7:0] portIdx;

  // Bank index: port base plus offset, flat over all ports
  always_comb begin
    portIdx = trigAddr[7:0];
  end

  // One clear strobe, to the counter that the trigger names
  always_comb begin
    clrVec = '0;
    if (portHit) begin
      clrVec[portIdx] = 1'b1;
    end
  end

  // One counter per bank entry; ports lie one after the other
  for (genvar i = 0; i < NCNT; i++) begin : g_port
    mibc_cnt_cell #(
      .W(mibc_pkg::CNT_W),
      .RST_VAL(mibc_pkg::CNT_RST)
    ) mibc_cnt_cell_inst (
      .clock(clock),
      .rst(rst),
      .inc(portEvent[i]),
      .clr(clrVec[i]),
      .count(cntVal[i]),
      .ovf(ovfVal[i])
    );
  end

  // ****************************************
  // Dropped-packet counters
  // ****************************************
  // These wrap silently at 16 bits and carry no flags, so the host has to
  // keep its own wrap count by polling often enough.
  logic [mibc_pkg::DROP_W-1:0] dropVal [NDROP];

  // Free-running 16-bit counts, never cleared by a read
  for (genvar i = 0; i < NDROP; i++) begin : g_drop
    mibc_cnt_cell #(
      .W(mibc_pkg::DROP_W),
      .RST_VAL(mibc_pkg::DROP_RST)
    ) mibc_cnt_cell_inst (
      .clock(clock),
      .rst(rst),
      .inc(dropEvent[i]),
      .clr(1'b0),
      .count(dropVal[i]),
      .ovf()  // No wrap flag on these
    );
  end

  // ****************************************
  // Readout snapshot
  // ****************************************
  // The word is taken whole at the trigger edge, so a count that moves
  // while the host walks the four data registers cannot tear it. The
  // clear lands on that same edge; an event in that cycle counts anew.
  // A second trigger before the last byte is read replaces the word.
  logic [mibc_pkg::CNT_W-1:0] portCnt;
  logic portOvf;
  logic [mibc_pkg::DROP_W-1:0] dropCnt;
  mibc_pkg::mibc_word_t snap_ff;
  mibc_pkg::mibc_word_t nxt_snap;
  logic done_ff;
  logic nxt_done;

  // Pick the addressed counter; the picks are only used behind a hit
  always_comb begin
    portCnt = cntVal[portIdx];
    portOvf = ovfVal[portIdx];
    dropCnt = dropVal[dropIdx[3:0]];
  end

  // Capture the selected word at the trigger, before the clear lands
  always_comb begin
    nxt_snap = snap_ff;
    nxt_done = 1'b0;
    if (portHit) begin
      nxt_snap.ovf = portOvf;
      nxt_snap.valid = 1'b1;
      nxt_snap.count = portCnt;
      nxt_done = 1'b1;
    end else if (dropHit) begin
      nxt_snap = mibc_pkg::WORD_RST;
      nxt_snap.count = {14'h0, dropCnt};
      nxt_done = 1'b1;
    end else if (trigWr && (isPortSel || isDropSel)) begin
      nxt_snap = mibc_pkg::WORD_RST;  // Unmapped address reads as a zero count
      nxt_snap.valid = isPortSel;
      nxt_done = 1'b1;
    end
  end

  // Register the snapshot
  always_ff @(posedge clock) begin
    if (rst) begin
      snap_ff <= mibc_pkg::WORD_RST;
      done_ff <= 1'b0;
    end else begin
      snap_ff <= nxt_snap;
      done_ff <= nxt_done;
    end
  end

  // ****************************************
  // Register read port
  // ****************************************
  // Reads have no side effect: a byte read twice gives the same value, and
  // only a new trigger changes what the data registers show.
  logic [7:0] rdData_ff;
  logic [7:0] nxt_rdData;
  logic rdValid_ff;
  logic nxt_rdValid;

  // Byte selection, most significant byte in the lowest register
  always_comb begin
    nxt_rdValid = mgmtReq.rd;
    nxt_rdData = rdData_ff;
    if (mgmtReq.rd) begin
      case (mgmtReq.addr)
        mibc_pkg::REG_SELECT: nxt_rdData = select_ff;
        mibc_pkg::REG_TRIGGER: nxt_rdData = trigger_ff;
        mibc_pkg::REG_DATA3: nxt_rdData = snap_ff[31:24];
        mibc_pkg::REG_DATA2: nxt_rdData = snap_ff[23:16];
        mibc_pkg::REG_DATA1: nxt_rdData = snap_ff[15:8];
        mibc_pkg::REG_DATA0: nxt_rdData = snap_ff[7:0];
        default: nxt_rdData = mibc_pkg::BYTE_RST;
      endcase
    end
  end

  // Register the read answer
  always_ff @(posedge clock) begin
    if (rst) begin
      rdData_ff <= mibc_pkg::BYTE_RST;
      rdValid_ff <= 1'b0;
    end else begin
      rdData_ff <= nxt_rdData;
      rdValid_ff <= nxt_rdValid;
    end
  end

  // Outputs
  assign mgmtRdData = rdData_ff;
  assign mgmtRdValid = rdValid_ff;
  assign readDone = done_ff;

endmodule

// ****************************************
// One event counter with read-clear and wrap flag
// ****************************************
module mibc_cnt_cell #(
  parameter int W = mibc_pkg::CNT_W,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Count and clear strobes
  input wire logic inc,
  input wire logic clr,
  // Current count and sticky wrap flag
  output logic [W-1:0] count,
  output logic ovf
);

  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;
  logic ovf_ff;
  logic nxt_ovf;
  logic wrap;

  // Clear first, then add the event, so a count in the clearing cycle is kept
  always_comb begin
    wrap = inc && (cnt_ff == {W{1'b1}});
    nxt_cnt = clr ? RST_VAL : cnt_ff;
    if (inc) begin
      nxt_cnt = nxt_cnt + W'(1);
    end
    // A wrap in the clearing cycle wins over the clear
    nxt_ovf = wrap || (ovf_ff && !clr);
  end

  // Register count and flag
  always_ff @(posedge clock) begin
    if (rst) begin
      cnt_ff <= RST_VAL;
      ovf_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      ovf_ff <= nxt_ovf;
    end
  end

  // Outputs
  assign count = cnt_ff;
  assign ovf = ovf_ff;

endmodule

// ---- verilog/mibc_pkg.sv ----
// Constants and types of the statistics counter readout block
package mibc_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int NUM_PORTS = 5;
  localparam int BANK_SIZE = 32;
  localparam int NUM_DROP = 10;
  localparam int CNT_W = 30;
  localparam int DROP_W = 16;

  // ****************************************
  // Management register numbers
  // ****************************************
  localparam logic [7:0] REG_SELECT = 8'h6E;   // 110
  localparam logic [7:0] REG_TRIGGER = 8'h6F;  // 111
  localparam logic [7:0] REG_DATA3 = 8'h75;    // 117, bits 31-24
  localparam logic [7:0] REG_DATA2 = 8'h76;    // 118, bits 23-16
  localparam logic [7:0] REG_DATA1 = 8'h77;    // 119, bits 15-8
  localparam logic [7:0] REG_DATA0 = 8'h78;    // 120, bits 7-0

  // ****************************************
  // Select values and indirect address map
  // ****************************************
  localparam logic [7:0] SEL_PORT_CNT = 8'h1C;
  localparam logic [7:0] SEL_DROP_CNT = 8'h1D;
  localparam logic [8:0] PORT1_BASE = 9'h000;
  localparam logic [8:0] PORT2_BASE = 9'h020;
  localparam logic [8:0] PORT3_BASE = 9'h040;
  localparam logic [8:0] PORT4_BASE = 9'h060;
  localparam logic [8:0] PORT5_BASE = 9'h080;
  localparam logic [8:0] PORT_END = 9'h0A0;
  localparam logic [8:0] DROP_BASE = 9'h100;
  localparam logic [8:0] DROP_END = 9'h10A;
  localparam logic [8:0] OFS_RX64 = 9'h00E;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int OVF_BIT = 31;
  localparam int VALID_BIT = 30;
  localparam logic [CNT_W-1:0] CNT_RST = 30'h0;
  localparam logic [DROP_W-1:0] DROP_RST = 16'h0;
  localparam logic [CNT_W-1:0] CNT_MAX = 30'h3FFFFFFF;
  localparam logic [7:0] BYTE_RST = 8'h00;

  // Counter word as returned to the host
  typedef struct packed {
    logic ovf;
    logic valid;
    logic [CNT_W-1:0] count;
  } mibc_word_t;

  localparam mibc_word_t WORD_RST = '{ovf: 1'b0, valid: 1'b0, count: CNT_RST};

  // One management register access
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mibc_req_t;

endpackage

// ---- test/mibc_host_model.sv ----
// Host model reading counters through the management registers
`timescale 1ns/1ns
module mibc_host_model (
  // Clock
  input wire logic clock,
  // Register access
  output mibc_pkg::mibc_req_t mgmtReq,
  input wire logic [7:0] mgmtRdData
);
  initial mgmtReq = '0;
  // One write, strobe held for one cycle
  task automatic wrReg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    mgmtReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock);
    mgmtReq <= '0;
  endtask
  // One read, byte taken once the answer has settled
  task automatic rdReg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    mgmtReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clock);
    mgmtReq <= '0;
    #1 d = mgmtRdData;
  endtask
  // Select, trigger, then bytes from the top; a drop word uses the low two only
  task automatic readWord(input logic drop, input logic [7:0] a, output logic [31:0] w);
    logic [7:0] b;
    w = '0;
    wrReg(8'h6E, drop ? 8'h1D : 8'h1C);
    wrReg(8'h6F, a);
    for (int i = drop ? 2 : 0; i < 4; i++) begin
      rdReg(8'(8'h75 + i), b);
      w = {w[23:0], b};
      if (i == 0 && !b[6]) begin
        i = -1;
        w = '0;
      end
    end
  endtask
endmodule

// ---- test/mibc_counter_read_monitor.sv ----
// Port checker for the counter readout block
`timescale 1ns/1ns
module mibc_counter_read_monitor #(
  parameter int NPORTS = 5,
  parameter int NDROP = 10
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Management access
  input wire mibc_pkg::mibc_req_t mgmtReq,
  input wire logic [7:0] mgmtRdData,
  input wire logic mgmtRdValid,
  // Events and status
  input wire logic [NPORTS*mibc_pkg::BANK_SIZE-1:0] portEvent,
  input wire logic [NDROP-1:0] dropEvent,
  input wire logic readDone
);
  logic [7:0] sel_ff;
  logic [7:0] nxt_sel;
  logic [1:0] kind_ff;
  logic [1:0] nxt_kind;
  logic trig;
  logic selOk;
  // Last select value and kind of last accepted trigger
  always_comb begin
    trig = mgmtReq.wr && mgmtReq.addr == 8'h6F;
    selOk = sel_ff == 8'h1C || sel_ff == 8'h1D;
    nxt_sel = (mgmtReq.wr && mgmtReq.addr == 8'h6E) ? mgmtReq.wdata : sel_ff;
    nxt_kind = (trig && selOk) ? (sel_ff[0] ? 2'h2 : 2'h1) : kind_ff;
  end
  // Helper registers
  always_ff @(posedge clock) begin
    sel_ff <= rst ? 8'h00 : nxt_sel;
    kind_ff <= rst ? 2'h0 : nxt_kind;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  property p_rdAns; mgmtReq.rd |=> mgmtRdValid; endproperty
  a_rdAns: assert property (p_rdAns) else $error("read not answered");
  property p_rdCause; mgmtRdValid |-> $past(mgmtReq.rd); endproperty
  a_rdCause: assert property (p_rdCause) else $error("answer without read");
  property p_hold; !mgmtRdValid |-> $stable(mgmtRdData); endproperty
  a_hold: assert property (p_hold) else $error("read byte changed");
  property p_done; trig && selOk |=> readDone; endproperty
  a_done: assert property (p_done) else $error("trigger not done");
  property p_ignore; trig && !selOk |=> !readDone; endproperty
  a_ignore: assert property (p_ignore) else $error("bad select done");
  property p_doneCause; readDone |-> $past(trig && selOk); endproperty
  a_doneCause: assert property (p_doneCause) else $error("stray done");
  property p_validTop; mgmtReq.rd && mgmtReq.addr == 8'h75 && kind_ff == 2'h1
    |=> mgmtRdData[6]; endproperty
  a_validTop: assert property (p_validTop) else $error("valid bit clear");
  property p_dropHi; mgmtReq.rd && mgmtReq.addr inside {8'h75, 8'h76} && kind_ff == 2'h2
    |=> mgmtRdData == 8'h00; endproperty
  a_dropHi: assert property (p_dropHi) else $error("drop high byte set");
endmodule
bind mibc_counter_read mibc_counter_read_monitor #(.NPORTS(NPORTS), .NDROP(NDROP))
  mibc_counter_read_monitor_inst (.clock(clock), .rst(rst), .mgmtReq(mgmtReq),
  .mgmtRdData(mgmtRdData), .mgmtRdValid(mgmtRdValid), .portEvent(portEvent),
  .dropEvent(dropEvent), .readDone(readDone));

// ---- test/testbench.sv ----
// Self-checking testbench for the counter readout block
`timescale 1ns/1ns
module testbench;
  logic clock;
  logic rst;
  mibc_pkg::mibc_req_t mgmtReq;
  logic [7:0] mgmtRdData;
  logic mgmtRdValid;
  logic [159:0] portEvent;
  logic [9:0] dropEvent;
  logic readDone;
  logic [31:0] w;
  int num_errors;
  int checked;
  initial clock = 1'b0;
  always #25 clock = ~clock;
  mibc_counter_read mibc_counter_read_inst (.clock(clock), .rst(rst), .mgmtReq(mgmtReq),
    .mgmtRdData(mgmtRdData), .mgmtRdValid(mgmtRdValid), .portEvent(portEvent),
    .dropEvent(dropEvent), .readDone(readDone));
  mibc_host_model mibc_host_model_inst (.clock(clock), .mgmtReq(mgmtReq),
    .mgmtRdData(mgmtRdData));
  // Word compare
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One pulse on one event input
  task automatic pulse(input logic drop, input int idx);
    @(posedge clock);
    if (drop) dropEvent[idx] <= 1'b1;
    else portEvent[idx] <= 1'b1;
    @(posedge clock);
    dropEvent <= '0;
    portEvent <= '0;
  endtask
  // Every bank at offsets 14 and 31; counts read back once, then cleared
  task automatic testPorts();
    mibc_host_model_inst.readWord(1'b0, 8'h00, w);
    chk(w, 32'h40000000);
    for (int p = 0; p < 5; p++) begin
      repeat (p + 1) pulse(1'b0, p * 32 + 14);
      pulse(1'b0, p * 32 + 31);
      mibc_host_model_inst.readWord(1'b0, 8'(p * 32 + 14), w);
      chk(w, 32'h40000001 + p);
      mibc_host_model_inst.readWord(1'b0, 8'(p * 32 + 14), w);
      chk(w, 32'h40000000);
      mibc_host_model_inst.readWord(1'b0, 8'(p * 32 + 31), w);
      chk(w, 32'h40000001);
    end
  endtask
  // Polling sweep: one event on every port counter, then each read once in turn
  task automatic testSweep();
    @(posedge clock);
    portEvent <= '1;
    @(posedge clock);
    portEvent <= '0;
    for (int a = 0; a < 160; a++) begin
      mibc_host_model_inst.readWord(1'b0, 8'(a), w);
      chk(w, 32'h40000001);
    end
  endtask
  // Drop counters: low 16 bits, kept across reads
  task automatic testDrops();
    logic [7:0] b;
    for (int i = 0; i < 10; i++) repeat (i + 1) pulse(1'b1, i);
    for (int i = 0; i < 10; i++) begin
      mibc_host_model_inst.readWord(1'b1, 8'(i), w);
      chk(w, 32'(i + 1));
      mibc_host_model_inst.readWord(1'b1, 8'(i), w);
      chk(w, 32'(i + 1));
    end
    mibc_host_model_inst.rdReg(8'h75, b);
    chk({24'h0, b}, 32'h0);
  endtask
  // Unknown select: trigger neither reads nor clears
  task automatic testIgnore();
    pulse(1'b0, 14);
    mibc_host_model_inst.wrReg(8'h6E, 8'h18);
    mibc_host_model_inst.wrReg(8'h6F, 8'h0E);
    mibc_host_model_inst.readWord(1'b0, 8'h0E, w);
    chk(w, 32'h40000001);
    mibc_host_model_inst.readWord(1'b0, 8'hA5, w);
    chk(w, 32'h40000000);
    mibc_host_model_inst.readWord(1'b1, 8'h0C, w);
    chk(w, 32'h0);
  endtask
  // Mid-run reset clears both kinds of counter
  task automatic testReset();
    pulse(1'b0, 5);
    pulse(1'b1, 3);
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    mibc_host_model_inst.readWord(1'b0, 8'h05, w);
    chk(w, 32'h40000000);
    mibc_host_model_inst.readWord(1'b1, 8'h03, w);
    chk(w, 32'h0);
  endtask
  // Verdict and end of run
  task automatic end_sim();
    $display("errors %0d, compares %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    rst = 1'b1;
    portEvent = '0;
    dropEvent = '0;
    num_errors = 0;
    checked = 0;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    testPorts();
    testSweep();
    testDrops();
    testIgnore();
    testReset();
    end_sim();
  end
  // Watchdog
  initial begin
    repeat (5000) @(posedge clock);
    num_errors++;
    end_sim();
  end
endmodule
